// ===== rtl/pii_map.svh
// Symbol codes, field positions and constants of the in-band link logic
`ifndef PII_MAP_SVH
`define PII_MAP_SVH
`define PII_K28_1 8'h3c
`define PII_K28_5 8'hbc
`define PII_D16_2 8'h50
`define PII_STAT_CTRL 8'h80
`define PII_RSV_BYTE 8'h00
`define PII_CGS_LAST 2'h2
`define PII_MSG_LAST 3'h5
`define PII_TMR_W 24
`define PII_CRC_POLY 8'h07
`define PII_CRC_INIT 8'h00
`endif

// ===== rtl/pii_pkg.sv
// Types of the in-band link logic: status states and the state records
package pii_pkg;
    typedef enum logic [2:0] {
        PII_ST_IDLE = 3'b001,
        PII_ST_SEND = 3'b010,
        PII_ST_WAIT = 3'b100
    } pii_st_t;

    typedef struct packed {
        logic [2:0] sleep_s;
        logic [2:0] pgood_s;
        logic sleep_q;
        logic pg_ok;
        logic link_en;
        logic data_idle;
        logic [2:0] txd_s;
        logic [2:0] rxc_s;
        logic [2:0] ack_s;
        logic [1:0] sync_s;
        logic tx_tog;
        logic [31:0] tx_msg;
        logic rsp_pend;
        logic [31:0] rsp_msg;
        pii_st_t st;
        logic on_smb;
        logic [15:0] st_last;
        logic [23:0] ibc;
        logic [23:0] diag;
        logic reg_req;
        logic reg_write;
        logic [4:0] reg_addr;
        logic [15:0] reg_wdata;
        logic [4:0] phy_addr;
    } pii_core_t;

    typedef struct packed {
        logic [2:0] en_s;
        logic en;
        logic [2:0] txt_s;
        logic tx_seen;
        logic done_tog;
        logic odd;
        logic [2:0] tx_idx;
        logic [7:0] tx_crc;
        logic [7:0] tx_byte;
        logic tx_k;
        logic [1:0] cgs;
        logic synced;
        logic [2:0] rx_idx;
        logic [7:0] rx_crc;
        logic [31:0] rx_buf;
        logic [31:0] rx_word;
        logic rx_tog;
        logic ack_tog;
    } pii_link_t;
endpackage : pii_pkg

// ===== rtl/pii_top.sv
// In-band interconnect logic of the PHY: interface selection, framing, status messages
`timescale 1ns/100ps
`include "pii_map.svh"

// Function
// (R1) In sleep, SMBus carries manageability traffic only.
// (R2) In sleep over SMBus, line rate is limited to 10 Mb/s.
// (R3) Awake: SMBus unused; serial link idles unless normal operation.
// (R4) Interface follows power state by itself; sleep powers serial link down.
// (R5) One receive and one transmit lane at 1.25 Gb/s each side.
// (R6) Controller supplies the 100 MHz reference clock.
// (R7) Platform reset release means power and clock good; link may start.
// (R8) Active-low clock request asks for or releases reference clock.
// (R9) Link runs at fixed 1250 Mb/s, no rate detection.
// (R10) Controller port takes its setup from nonvolatile memory.
// (R11) Link carries whole Ethernet frames, never PCIe packets.
// (R12) After power-up send idle sets; receiver gains code-group sync.
// (R13) Device originates only status messages, then waits for acknowledge.
// (R14) Interface switch before acknowledge resends message on new interface.
// (R15) Each serial in-band message has an SMBus counterpart.
// (R16) Register packet starts with K28.1, ends with CRC-8 over the rest.
// (R17) Control byte: bits 7,6 clear, bit 5 write, bits 4:0 address.
// (R18) Write data high byte then low; zeros on a read.
// (R19) Byte before CRC holds 5-bit PHY address, upper bits zero.
// (R20) Answer: acknowledge control byte, data high, low, zero byte, CRC.
// (R21) Status sent on status change or in-band control timeout.
// (R22) Status resent when no acknowledge before diagnostic timeout.
// (R23) CRC polynomial and seed are parameters; bad CRC packets dropped.
// (R24) Reserved bits ignored on receive and sent as zero.
module pii_top #(
    parameter logic [7:0] CRC_POLY = `PII_CRC_POLY,
    parameter logic [7:0] CRC_INIT = `PII_CRC_INIT
) (
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    input wire logic link_clk_in,
    input wire logic link_rstn_in,
    input wire logic sys_sleep_in,
    input wire logic platform_power_clock_good_n_in,
    input wire logic phy_pwrdn_in,
    input wire logic phy_link_idle_in,
    input wire logic phy_lpi_in,
    input wire logic [15:0] phy_status_in,
    input wire logic [23:0] ibc_timeout_in,
    input wire logic [23:0] diag_timeout_in,
    input wire logic reg_done_in,
    input wire logic [15:0] reg_rdata_in,
    input wire logic smb_ack_in,
    input wire logic [7:0] rx_data_in,
    input wire logic rx_k_in,
    input wire logic rx_err_in,
    output logic [7:0] tx_data_out,
    output logic tx_k_out,
    output logic tx_elec_idle_out,
    output logic reg_req_out,
    output logic reg_write_out,
    output logic [4:0] reg_addr_out,
    output logic [15:0] reg_wdata_out,
    output logic [4:0] phy_addr_out,
    output logic smb_msg_valid_out,
    output logic [15:0] smb_msg_out,
    output logic smb_mgmt_only_out,
    output logic speed_limit_10m_out,
    output logic serdes_pwrdn_out,
    output logic serdes_data_idle_out,
    output logic refclk_request_n_out,
    output logic link_sync_out
);

    pii_pkg::pii_core_t c_ff, nxt_c;
    pii_pkg::pii_link_t l_ff, nxt_l;
    logic busy, link_ok, ack_ev, st_done, diag_exp;

    // CRC-8 step, one byte msb first; polynomial left open to the integrator
    function automatic logic [7:0] pii_crc8(input logic [7:0] crc, input logic [7:0] d);
        logic [7:0] r;
        r = crc ^ d;
        for (int i = 0; i < 8; i++) begin
            r = r[7] ? ({r[6:0], 1'b0} ^ CRC_POLY) : {r[6:0], 1'b0};
        end
        return r;
    endfunction : pii_crc8

    ////////////////////////////////////////////////////////////////////////////////
    // Core clock domain

    // Handshake terms shared by the state logic and the checks
    assign busy = c_ff.tx_tog != c_ff.txd_s[2];
    assign link_ok = !c_ff.sleep_q && c_ff.pg_ok && c_ff.sync_s[1];
    assign ack_ev = c_ff.ack_s[2] != c_ff.ack_s[1];
    assign st_done = (ack_ev && !c_ff.on_smb) || (smb_ack_in && c_ff.on_smb);
    assign diag_exp = diag_timeout_in != 24'h0 && c_ff.diag >= diag_timeout_in;

    // Next core state
    always_comb begin
        logic issue;
        issue = 1'b0;
        nxt_c = c_ff;
        nxt_c.reg_req = 1'b0;
        // Pins pass three stages; a change counts once stages two and three agree
        nxt_c.sleep_s = {c_ff.sleep_s[1:0], sys_sleep_in};
        nxt_c.pgood_s = {c_ff.pgood_s[1:0], platform_power_clock_good_n_in};
        if (c_ff.sleep_s[2] == c_ff.sleep_s[1]) begin
            nxt_c.sleep_q = c_ff.sleep_s[2];
        end
        if (c_ff.pgood_s[2] == c_ff.pgood_s[1]) begin
            nxt_c.pg_ok = c_ff.pgood_s[2]; // see (R7)
        end
        nxt_c.txd_s = {c_ff.txd_s[1:0], l_ff.done_tog};
        nxt_c.rxc_s = {c_ff.rxc_s[1:0], l_ff.rx_tog};
        nxt_c.ack_s = {c_ff.ack_s[1:0], l_ff.ack_tog};
        nxt_c.sync_s = {c_ff.sync_s[0], l_ff.synced};
        // Serial link only runs awake with good power and clock; follows the qualified
        // levels in the same edge so the serdes never runs a cycle into sleep
        nxt_c.link_en = !nxt_c.sleep_q && nxt_c.pg_ok; // see (R4) see (R7)
        nxt_c.data_idle = !c_ff.sleep_q && (phy_pwrdn_in || phy_link_idle_in || phy_lpi_in); // see (R3)
        // Register command from the link; reserved address bits dropped
        if (c_ff.rxc_s[2] != c_ff.rxc_s[1]) begin
            nxt_c.reg_req = 1'b1;
            nxt_c.reg_write = l_ff.rx_word[29]; // see (R17)
            nxt_c.reg_addr = l_ff.rx_word[28:24];
            nxt_c.reg_wdata = l_ff.rx_word[23:8]; // see (R18)
            nxt_c.phy_addr = l_ff.rx_word[4:0]; // see (R19) see (R24)
        end
        // Answers go ahead of status so the controller is never left hanging
        if (c_ff.rsp_pend && link_ok && !busy) begin
            nxt_c.tx_msg = c_ff.rsp_msg;
            nxt_c.tx_tog = ~c_ff.tx_tog;
            nxt_c.rsp_pend = 1'b0;
            issue = 1'b1;
        end
        // Set after clear: a new answer is never lost
        if (reg_done_in) begin
            nxt_c.rsp_pend = 1'b1;
            nxt_c.rsp_msg = {2'b01, c_ff.reg_write, c_ff.reg_addr, reg_rdata_in, `PII_RSV_BYTE}; // see (R20)
        end
        // Status message sequence
        unique case (c_ff.st)
            pii_pkg::PII_ST_IDLE: begin
                nxt_c.ibc = c_ff.ibc + 24'h1;
                if (phy_status_in != c_ff.st_last ||
                    (ibc_timeout_in != 24'h0 && c_ff.ibc >= ibc_timeout_in)) begin // see (R21)
                    nxt_c.st_last = phy_status_in;
                    nxt_c.ibc = 24'h0;
                    nxt_c.st = pii_pkg::PII_ST_SEND;
                end
            end
            pii_pkg::PII_ST_SEND: begin
                nxt_c.diag = 24'h0;
                if (c_ff.sleep_q) begin
                    nxt_c.on_smb = 1'b1; // see (R4) see (R15)
                    nxt_c.st = pii_pkg::PII_ST_WAIT;
                end else if (link_ok && !busy && !issue) begin
                    nxt_c.tx_msg = {`PII_STAT_CTRL, c_ff.st_last, `PII_RSV_BYTE}; // see (R24)
                    nxt_c.tx_tog = ~c_ff.tx_tog;
                    nxt_c.on_smb = 1'b0;
                    nxt_c.st = pii_pkg::PII_ST_WAIT; // see (R13)
                end
            end
            pii_pkg::PII_ST_WAIT: begin
                nxt_c.diag = c_ff.diag + 24'h1;
                if (st_done) begin
                    nxt_c.ibc = 24'h0;
                    nxt_c.st = pii_pkg::PII_ST_IDLE; // see (R13)
                end else if (c_ff.sleep_q != c_ff.on_smb) begin
                    nxt_c.st = pii_pkg::PII_ST_SEND; // see (R14)
                end else if (diag_exp) begin
                    nxt_c.st = pii_pkg::PII_ST_SEND; // see (R22)
                end
            end
            default: begin
                nxt_c.st = pii_pkg::PII_ST_IDLE;
            end
        endcase
    end

    // Core state register
    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            c_ff <= '0;
            c_ff.st <= pii_pkg::PII_ST_IDLE;
        end else begin
            c_ff <= nxt_c;
        end
    end

    // Core outputs from flip-flops; smb_msg_valid_out gates on_smb with the wait state
    assign reg_req_out = c_ff.reg_req;
    assign reg_write_out = c_ff.reg_write;
    assign reg_addr_out = c_ff.reg_addr;
    assign reg_wdata_out = c_ff.reg_wdata;
    assign phy_addr_out = c_ff.phy_addr;
    assign smb_msg_valid_out = c_ff.on_smb && c_ff.st == pii_pkg::PII_ST_WAIT; // see (R3)
    assign smb_msg_out = c_ff.st_last;
    assign smb_mgmt_only_out = c_ff.sleep_q; // see (R1)
    assign speed_limit_10m_out = c_ff.sleep_q; // see (R2)
    assign serdes_pwrdn_out = !c_ff.link_en; // see (R4)
    assign serdes_data_idle_out = c_ff.data_idle; // see (R3)
    // Clock is requested whenever awake, before power-good so training can start
    assign refclk_request_n_out = c_ff.sleep_q; // see (R8)
    assign link_sync_out = c_ff.sync_s[1];

    ////////////////////////////////////////////////////////////////////////////////
    // Link clock domain

    // Next link state: idle sets, message framing, sync and receive parsing
    always_comb begin
        logic [31:0] sh;
        sh = c_ff.tx_msg << {l_ff.tx_idx - 3'h1, 3'h0};
        nxt_l = l_ff;
        nxt_l.en_s = {l_ff.en_s[1:0], c_ff.link_en};
        nxt_l.txt_s = {l_ff.txt_s[1:0], c_ff.tx_tog};
        if (l_ff.en_s[2] == l_ff.en_s[1]) begin
            nxt_l.en = l_ff.en_s[2];
        end
        // Disabled link drops any queued message so the core never stalls
        if (!l_ff.en) begin
            nxt_l.tx_byte = 8'h00;
            nxt_l.tx_k = 1'b0;
            nxt_l.tx_idx = 3'h0;
            nxt_l.odd = 1'b0;
            nxt_l.tx_seen = l_ff.txt_s[2];
            nxt_l.done_tog = l_ff.txt_s[2];
        end else if (l_ff.tx_idx == 3'h0) begin
            // Messages start only on an ordered-set boundary
            if (!l_ff.odd && l_ff.txt_s[2] != l_ff.tx_seen) begin
                nxt_l.tx_seen = l_ff.txt_s[2];
                nxt_l.tx_byte = `PII_K28_1; // see (R16)
                nxt_l.tx_k = 1'b1;
                nxt_l.tx_idx = 3'h1;
                nxt_l.tx_crc = CRC_INIT;
            end else begin
                nxt_l.tx_byte = l_ff.odd ? `PII_D16_2 : `PII_K28_5; // see (R12)
                nxt_l.tx_k = !l_ff.odd;
                nxt_l.odd = !l_ff.odd;
            end
        end else if (l_ff.tx_idx < `PII_MSG_LAST) begin
            nxt_l.tx_byte = sh[31:24];
            nxt_l.tx_k = 1'b0;
            nxt_l.tx_crc = pii_crc8(l_ff.tx_crc, sh[31:24]); // see (R16) see (R23)
            nxt_l.tx_idx = l_ff.tx_idx + 3'h1;
        end else begin
            nxt_l.tx_byte = l_ff.tx_crc;
            nxt_l.tx_k = 1'b0;
            nxt_l.tx_idx = 3'h0;
            nxt_l.done_tog = l_ff.tx_seen;
        end
        // Code-group sync: three clean commas acquire, any code error drops
        if (rx_err_in) begin
            nxt_l.cgs = 2'h0;
            nxt_l.synced = 1'b0; // see (R12)
        end else if (rx_k_in && rx_data_in == `PII_K28_5) begin
            if (l_ff.cgs == `PII_CGS_LAST) begin
                nxt_l.synced = 1'b1;
            end else begin
                nxt_l.cgs = l_ff.cgs + 2'h1;
            end
        end
        // Only K28.1 opens an in-band packet; frame data is left to the MAC path
        if (!l_ff.synced) begin
            nxt_l.rx_idx = 3'h0; // see (R11)
        end else if (rx_k_in && rx_data_in == `PII_K28_1) begin
            nxt_l.rx_idx = 3'h1;
            nxt_l.rx_crc = CRC_INIT; // see (R16)
        end else if (rx_k_in || rx_err_in) begin
            nxt_l.rx_idx = 3'h0;
        end else if (l_ff.rx_idx != 3'h0 && l_ff.rx_idx < `PII_MSG_LAST) begin
            nxt_l.rx_buf = {l_ff.rx_buf[23:0], rx_data_in};
            nxt_l.rx_crc = pii_crc8(l_ff.rx_crc, rx_data_in);
            nxt_l.rx_idx = l_ff.rx_idx + 3'h1;
        end else if (l_ff.rx_idx == `PII_MSG_LAST) begin
            nxt_l.rx_idx = 3'h0;
            // Mismatched CRC drops the packet silently
            if (rx_data_in == l_ff.rx_crc) begin // see (R23)
                if (l_ff.rx_buf[31:30] == 2'b00) begin
                    nxt_l.rx_word = l_ff.rx_buf;
                    nxt_l.rx_tog = !l_ff.rx_tog; // see (R17)
                end else if (l_ff.rx_buf[31:30] == 2'b11) begin
                    nxt_l.ack_tog = !l_ff.ack_tog; // see (R13) see (R24)
                end
            end
        end
    end

    // Link state register
    always_ff @(posedge link_clk_in) begin
        if (!link_rstn_in) begin
            l_ff <= '0;
        end else begin
            l_ff <= nxt_l;
        end
    end

    // One symbol per link clock, one lane each way at the fixed rate
    assign tx_data_out = l_ff.tx_byte; // see (R5) see (R9)
    assign tx_k_out = l_ff.tx_k;
    assign tx_elec_idle_out = !l_ff.en;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    chk_sleep_mgmt: assert property (@(posedge ref_clk_in) disable iff (!rstn_in) // see (R1)
        $rose(c_ff.sleep_q) |-> smb_mgmt_only_out && !reg_req_out ##1 smb_mgmt_only_out)
        else $error("sleep without manageability-only smbus");
    chk_speed_limit: assert property (@(posedge ref_clk_in) disable iff (!rstn_in) // see (R2)
        c_ff.sleep_q |-> speed_limit_10m_out && serdes_pwrdn_out)
        else $error("sleep without 10 Mb/s limit");
    chk_smb_quiet: assert property (@(posedge ref_clk_in) disable iff (!rstn_in) // see (R3)
        !c_ff.sleep_q && !c_ff.on_smb |-> !smb_msg_valid_out)
        else $error("smbus used while awake");
    chk_clk_request: assert property (@(posedge ref_clk_in) disable iff (!rstn_in) // see (R8)
        $rose(c_ff.sleep_q) |=> refclk_request_n_out ##1 serdes_pwrdn_out)
        else $error("clock request kept in sleep");
    chk_pgood_gate: assert property (@(posedge ref_clk_in) disable iff (!rstn_in) // see (R7)
        !c_ff.pg_ok |-> serdes_pwrdn_out)
        else $error("link enabled before power good");
    chk_wait_hold: assert property (@(posedge ref_clk_in) disable iff (!rstn_in) // see (R13)
        c_ff.st == pii_pkg::PII_ST_WAIT && !st_done && !diag_exp && c_ff.sleep_q == c_ff.on_smb
        |=> c_ff.st == pii_pkg::PII_ST_WAIT)
        else $error("status left wait without acknowledge");
    chk_switch_resend: assert property (@(posedge ref_clk_in) disable iff (!rstn_in) // see (R14)
        c_ff.st == pii_pkg::PII_ST_WAIT && !st_done && c_ff.sleep_q != c_ff.on_smb
        |=> c_ff.st == pii_pkg::PII_ST_SEND)
        else $error("no resend after interface switch");
    chk_diag_retry: assert property (@(posedge ref_clk_in) disable iff (!rstn_in) // see (R22)
        c_ff.st == pii_pkg::PII_ST_WAIT && !st_done && diag_exp |=> c_ff.st == pii_pkg::PII_ST_SEND)
        else $error("no retry after diagnostic timeout");
    chk_status_change: assert property (@(posedge ref_clk_in) disable iff (!rstn_in) // see (R21)
        c_ff.st == pii_pkg::PII_ST_IDLE && phy_status_in != c_ff.st_last
        |=> c_ff.st == pii_pkg::PII_ST_SEND && c_ff.st_last == $past(phy_status_in))
        else $error("status change not sent");
    chk_answer_form: assert property (@(posedge ref_clk_in) disable iff (!rstn_in) // see (R20)
        reg_done_in |=> c_ff.rsp_pend && c_ff.rsp_msg[31:30] == 2'b01 && c_ff.rsp_msg[7:0] == 8'h00)
        else $error("bad register answer");
    chk_frame_len: assert property (@(posedge link_clk_in) disable iff (!link_rstn_in) // see (R16)
        tx_k_out && tx_data_out == `PII_K28_1 |=> !tx_k_out [*5])
        else $error("in-band packet not five data bytes");
    chk_idle_set: assert property (@(posedge link_clk_in) disable iff (!link_rstn_in) // see (R12)
        tx_k_out && tx_data_out == `PII_K28_5 && l_ff.en |=> tx_data_out == `PII_D16_2 || !l_ff.en)
        else $error("broken idle ordered set");

endmodule : pii_top

// ===== tb/pii_ctrl_model.sv
// Controller-side partner model: idle sets, in-band packets, capture of device frames
`timescale 1ns/100ps
`include "pii_map.svh"

module pii_ctrl_model (
    input wire logic link_clk_in,
    input wire logic [7:0] tx_data_in,
    input wire logic tx_k_in,
    output logic [7:0] rx_data_out,
    output logic rx_k_out,
    output logic rx_err_out
);
    logic [9:0] sym_q[$];
    logic [7:0] got_q[$];
    logic comma_ff = 1'b0;
    int cap_cnt = 0;

    ////////////////////////////////////////
    // CRC-8, msb first, same seed and polynomial as the device
    function automatic logic [7:0] crc8(input logic [31:0] w);
        logic [7:0] c;
        c = `PII_CRC_INIT;
        for (int i = 31; i >= 0; i--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? `PII_CRC_POLY : 8'h00);
        end
        return c;
    endfunction : crc8

    // Queue one packet; bad inverts the check byte on purpose
    task automatic send_pkt(input logic [31:0] w, input logic bad);
        sym_q.push_back({2'b01, `PII_K28_1});
        for (int i = 3; i >= 0; i--) begin
            sym_q.push_back({2'b00, w[i*8 +: 8]});
        end
        sym_q.push_back({2'b00, crc8(w) ^ {8{bad}}});
        wait (sym_q.size() == 0);
    endtask : send_pkt

    ////////////////////////////////////////
    // Queued symbols first, else idle sets so the receiver keeps sync
    always @(negedge link_clk_in) begin
        if (sym_q.size() != 0) begin
            {rx_err_out, rx_k_out, rx_data_out} <= sym_q.pop_front();
        end else begin
            rx_err_out <= 1'b0;
            rx_k_out <= ~comma_ff;
            rx_data_out <= comma_ff ? `PII_D16_2 : `PII_K28_5;
            comma_ff <= ~comma_ff;
        end
    end

    // Capture the five bytes after each K28.1 sent by the device
    always @(posedge link_clk_in) begin
        if (cap_cnt != 0) begin
            got_q.push_back(tx_data_in);
            cap_cnt <= cap_cnt - 1;
        end else if (tx_k_in === 1'b1 && tx_data_in === `PII_K28_1) begin
            cap_cnt <= 5;
        end
    end
endmodule : pii_ctrl_model

// ===== tb/testbench.sv
// Self-checking bench of the in-band link logic against a controller model
`timescale 1ns/100ps
`include "pii_map.svh"

module testbench;
    logic ref_clk, link_clk, rstn, link_rstn, sleep, pgood_n, pwrdn, lidle, lpi, done, sack;
    logic rxk, rxe, txk, eidle, rreq, rwr, smbv, mgmt, lim10, sdpd, sdidle, ckreq_n, sync;
    logic [15:0] status, rdata, wdata, smsg;
    logic [23:0] ibc, diag;
    logic [7:0] rxd, txd;
    logic [4:0] raddr, paddr;
    logic [7:0] f[5];
    int fail_count = 0;
    int checks_done = 0;
    int cyc = 0;

    pii_top i_dut (.ref_clk_in(ref_clk), .rstn_in(rstn), .link_clk_in(link_clk),
        .link_rstn_in(link_rstn), .sys_sleep_in(sleep), .platform_power_clock_good_n_in(pgood_n),
        .phy_pwrdn_in(pwrdn), .phy_link_idle_in(lidle), .phy_lpi_in(lpi),
        .phy_status_in(status), .ibc_timeout_in(ibc), .diag_timeout_in(diag),
        .reg_done_in(done), .reg_rdata_in(rdata), .smb_ack_in(sack), .rx_data_in(rxd),
        .rx_k_in(rxk), .rx_err_in(rxe), .tx_data_out(txd), .tx_k_out(txk),
        .tx_elec_idle_out(eidle), .reg_req_out(rreq), .reg_write_out(rwr),
        .reg_addr_out(raddr), .reg_wdata_out(wdata), .phy_addr_out(paddr),
        .smb_msg_valid_out(smbv), .smb_msg_out(smsg), .smb_mgmt_only_out(mgmt),
        .speed_limit_10m_out(lim10), .serdes_pwrdn_out(sdpd), .serdes_data_idle_out(sdidle),
        .refclk_request_n_out(ckreq_n), .link_sync_out(sync));

    pii_ctrl_model i_ctrl (.link_clk_in(link_clk), .tx_data_in(txd), .tx_k_in(txk),
        .rx_data_out(rxd), .rx_k_out(rxk), .rx_err_out(rxe));

    ////////////////////////////////////////
    // Core clock 200 MHz; link clock 125 ns with an unrelated phase, fixed rate
    // with no training, as the controller supplies it
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    initial begin
        link_clk = 1'b0;
        #7.3;
        forever #62.5 link_clk = ~link_clk;
    end

    // Cut a hang short; ceiling well above the expected run
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            fail_count++;
            tally_and_finish();
        end
    end

    ////////////////////////////////////////
    task automatic chk1(input string n, input logic e, input logic g);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %b seen %b", n, e, g);
        end
    endtask : chk1

    task automatic chk16(input string n, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk16

    // Bounded wait for a level, then judge it
    task automatic wait_for(input string n, ref logic s, input logic v, input int lim);
        int t;
        t = 0;
        while (s !== v && t < lim) begin
            @(negedge ref_clk);
            t++;
        end
        chk1(n, v, s);
    endtask : wait_for

    // Next device frame against its four bytes and check byte
    task automatic chk_frame(input string n, input logic [31:0] w);
        int t;
        t = 0;
        while (i_ctrl.got_q.size() < 5 && t < 4000) begin
            @(negedge ref_clk);
            t++;
        end
        for (int i = 0; i < 5; i++) begin
            f[i] = (i_ctrl.got_q.size() != 0) ? i_ctrl.got_q.pop_front() : 8'hxx;
        end
        chk16(n, w[31:16], {f[0], f[1]});
        chk16(n, w[15:0], {f[2], f[3]});
        chk16(n, {8'h00, i_ctrl.crc8(w)}, {8'h00, f[4]});
    endtask : chk_frame

    ////////////////////////////////////////
    // Platform reset still asserted: link must stay down
    task automatic t_reset();
        repeat (100) @(negedge ref_clk);
        chk1("refclk_request_n", 1'b0, ckreq_n);
        chk1("serdes_pwrdn", 1'b1, sdpd);
        chk1("tx_elec_idle", 1'b1, eidle);
    endtask : t_reset

    // Power good starts the link; idle sets, sync, data-idle cases
    task automatic t_power_up();
        logic [8:0] a, b;
        pgood_n = 1'b1;
        wait_for("serdes_pwrdn", sdpd, 1'b0, 20);
        wait_for("tx_elec_idle", eidle, 1'b0, 1500);
        wait_for("link_sync", sync, 1'b1, 1500);
        chk1("mgmt_only", 1'b0, mgmt);
        chk1("speed_limit", 1'b0, lim10);
        @(posedge link_clk);
        #1 a = {txk, txd};
        @(posedge link_clk);
        #1 b = {txk, txd};
        chk1("idle set", 1'b1, ({a, b} === {1'b1, `PII_K28_5, 1'b0, `PII_D16_2})
            || ({b, a} === {1'b1, `PII_K28_5, 1'b0, `PII_D16_2}));
        for (int i = 0; i < 3; i++) begin
            @(negedge ref_clk);
            {pwrdn, lidle, lpi} = 3'b100 >> i;
            wait_for("data_idle on", sdidle, 1'b1, 20);
            {pwrdn, lidle, lpi} = 3'b000;
            wait_for("data_idle off", sdidle, 1'b0, 20);
        end
        i_ctrl.sym_q.push_back(10'h200);
        wait_for("sync lost", sync, 1'b0, 200);
        wait_for("sync again", sync, 1'b1, 800);
    endtask : t_power_up

    // Write then read access and the framed answers
    task automatic t_reg();
        logic [31:0] w;
        logic wr;
        for (int i = 0; i < 2; i++) begin
            wr = ~i[0];
            w = {2'b00, wr, 5'h15, wr ? 16'hbeef : 16'h0000, 3'b111, 5'h0a};
            i_ctrl.send_pkt(w, 1'b0);
            wait_for("reg_req", rreq, 1'b1, 200);
            chk1("reg_write", wr, rwr);
            chk16("reg_addr", 16'h0015, {11'h000, raddr});
            chk16("reg_wdata", w[23:8], wdata);
            chk16("phy_addr", 16'h000a, {11'h000, paddr});
            rdata = wr ? 16'hc3a5 : 16'h5a96;
            done = 1'b1;
            @(negedge ref_clk);
            done = 1'b0;
            chk_frame("reply", {2'b01, wr, 5'h15, rdata, 8'h00});
        end
    endtask : t_reg

    // Corrupted check byte: no register access may follow
    task automatic t_bad_crc();
        int hits;
        hits = 0;
        i_ctrl.send_pkt({8'h20, 16'h1234, 8'h01}, 1'b1);
        repeat (300) begin
            @(negedge ref_clk);
            if (rreq !== 1'b0) hits++;
        end
        chk16("bad crc requests", 16'h0000, hits[15:0]);
    endtask : t_bad_crc

    // Status change, retry without answer, silence after acknowledge
    task automatic t_status();
        diag = 24'd3000;
        status = 16'h2c0a;
        chk_frame("status", {`PII_STAT_CTRL, 16'h2c0a, 8'h00});
        chk_frame("status retry", {`PII_STAT_CTRL, 16'h2c0a, 8'h00});
        i_ctrl.send_pkt({8'hc0, 16'h2c0a, 8'h00}, 1'b0);
        repeat (4000) @(negedge ref_clk);
        chk16("frames after ack", 16'h0000, 16'(i_ctrl.got_q.size()));
    endtask : t_status

    // Sleep before acknowledge moves the status to SMBus
    task automatic t_sleep();
        status = 16'h0183;
        chk_frame("status", {`PII_STAT_CTRL, 16'h0183, 8'h00});
        sleep = 1'b1;
        wait_for("smb_msg_valid", smbv, 1'b1, 200);
        chk16("smb_msg", 16'h0183, smsg);
        chk1("mgmt_only", 1'b1, mgmt);
        chk1("speed_limit", 1'b1, lim10);
        chk1("serdes_pwrdn", 1'b1, sdpd);
        chk1("refclk_request_n", 1'b1, ckreq_n);
        sack = 1'b1;
        @(negedge ref_clk);
        sack = 1'b0;
        wait_for("smb_msg_valid off", smbv, 1'b0, 20);
    endtask : t_sleep

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish

    ////////////////////////////////////////
    // Main sequence; inputs change on the falling core edge, link reset on the falling link edge
    initial begin
        {rstn, link_rstn, sleep, done, sack, pwrdn, lidle, lpi} = 8'h00;
        pgood_n = 1'b0;
        {status, rdata} = 32'h0000_0000;
        {ibc, diag} = 48'h0000_0000_0000;
        repeat (16) @(negedge ref_clk);
        rstn = 1'b1;
        repeat (2) @(posedge link_clk);
        @(negedge link_clk);
        link_rstn = 1'b1;
        @(negedge ref_clk);
        t_reset();
        t_power_up();
        t_reg();
        t_bad_crc();
        t_status();
        t_sleep();
        tally_and_finish();
    end
endmodule : testbench
